// ---- logic/swd_pkg.sv ----
package swd_pkg;

  localparam int unsigned NumSrc = 4;

  // Source slots, one byte lane of the mode register each
  localparam int unsigned SrcCalendar = 0;
  localparam int unsigned SrcSix      = 1;
  localparam int unsigned SrcSeven    = 2;
  localparam int unsigned SrcRemote   = 3;

  // Register word indices; byte address is four times the index
  localparam logic [5:0] IdxMode    = 6'h00;
  localparam logic [5:0] IdxClear   = 6'h01;
  localparam logic [5:0] IdxPending = 6'h02;

  // Field layout inside each source byte; ClrLsb is the code position in the clear word
  localparam int unsigned SrcStride = 8;
  localparam int unsigned EnPos     = 0;
  localparam int unsigned SeenLsb   = 2;
  localparam int unsigned ModeLsb   = 4;
  localparam int unsigned ClrLsb    = 0;

  typedef enum logic [2:0] {
    ModeLow  = 3'h0,
    ModeHigh = 3'h1,
    ModeFall = 3'h2,
    ModeRise = 3'h3,
    ModeBoth = 3'h4
  } swd_mode_t;

  localparam logic [2:0] ModeReset = 3'h2;
  localparam logic       EnReset   = 1'h0;

  localparam logic [1:0] SeenNone = 2'h0;
  localparam logic [1:0] SeenRise = 2'h1;
  localparam logic [1:0] SeenFall = 2'h2;

  // Request-clear codes per slot, slot 0 in the low bits
  localparam logic [19:0] ClrCodes = {5'h0B, 5'h0A, 5'h09, 5'h08};

endpackage

// ---- logic/swd_if.sv ----
`timescale 1ns/1ps

interface swd_src_if;
  logic [2:0] mode;
  logic       enable;
  logic       clear;
  logic       request;
  logic [1:0] seen;
  modport ctl (output mode, output enable, output clear,
               input request, input seen);
  modport det (input mode, input enable, input clear,
               output request, output seen);
endinterface

interface swd_reg_if;
  logic        wrStb;
  logic [5:0]  index;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slv  (output wrStb, output index, output wdata, input rdata);
  modport core (input wrStb, input index, input wdata, output rdata);
endinterface

// ---- logic/swd_detect.sv ----
`timescale 1ns/1ps

module swd_detect (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic sigIn,
  swd_src_if.det    src
);

  typedef struct packed {
    logic       prev;
    logic       primed;
    logic       req;
    logic [1:0] seen;
  } swd_det_state_t;

  swd_det_state_t state_q;
  swd_det_state_t state_d;
  logic           rise;
  logic           fall;
  logic           hit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    // No edge before the first sample, avoids a false edge out of reset
    rise = state_q.primed & sigIn & ~state_q.prev;
    fall = state_q.primed & ~sigIn & state_q.prev;
    case (src.mode)
      swd_pkg::ModeLow:  hit = ~sigIn;
      swd_pkg::ModeHigh: hit = sigIn;
      swd_pkg::ModeFall: hit = fall;
      swd_pkg::ModeRise: hit = rise;
      swd_pkg::ModeBoth: hit = rise | fall;
      default:           hit = 1'b0;
    endcase
    state_d.prev   = sigIn;
    state_d.primed = 1'b1;
    state_d.req = (state_q.req & ~src.clear) | (src.enable & hit);
    if (src.clear) begin
      state_d.seen = swd_pkg::SeenNone;
    end
    if (src.mode == swd_pkg::ModeBoth && src.enable) begin
      state_d.seen = state_d.seen
                   | (rise ? swd_pkg::SeenRise : swd_pkg::SeenNone)
                   | (fall ? swd_pkg::SeenFall : swd_pkg::SeenNone);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign src.request = state_q.req;
  assign src.seen    = state_q.seen;

endmodule

// ---- logic/swd_avs.sv ----
`timescale 1ns/1ps

module swd_avs (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  swd_reg_if.slv           rb
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } swd_avs_state_t;

  swd_avs_state_t state_q;
  swd_avs_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed one wait cycle: read data latched in the first cycle
  always_comb begin
    state_d     = state_q;
    state_d.ack = (avs_read | avs_write) & ~state_q.ack;
    if (avs_read && !state_q.ack) begin
      state_d.rdata = rb.rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~state_q.ack;
  assign avs_readdata    = state_q.rdata;
  assign rb.wrStb        = avs_write & state_q.ack;
  assign rb.index        = avs_address[7:2];
  assign rb.wdata        = avs_writedata;

endmodule

// ---- logic/swd_top.sv ----
// Behaviour
// - input seven mode field, five codes
// - input six mode field, same codes
// - seen-edge fields report rise, fall, both
// - seen edge valid only in both-edge mode
// - request clear also wipes seen edge
`timescale 1ns/1ps

module swd_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        extIrqSix,
  input  wire logic        extIrqSeven,
  input  wire logic        remoteReceiveOneEvent,
  input  wire logic        clockCalendarEvent,
  output logic      [3:0]  wakeRequest
);

  typedef struct packed {
    logic [swd_pkg::NumSrc-1:0][2:0] mode;
    logic [swd_pkg::NumSrc-1:0]      enable;
  } swd_top_state_t;

  swd_top_state_t             state_q;
  swd_top_state_t             state_d;
  logic [swd_pkg::NumSrc-1:0] sigIn;
  logic [swd_pkg::NumSrc-1:0] reqVec;
  logic [swd_pkg::NumSrc-1:0][1:0] seenVec;

  swd_reg_if rb ();
  swd_src_if src [swd_pkg::NumSrc] ();

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] packMode(
    input logic [swd_pkg::NumSrc-1:0][2:0] mode,
    input logic [swd_pkg::NumSrc-1:0]      enable,
    input logic [swd_pkg::NumSrc-1:0][1:0] seen
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < swd_pkg::NumSrc; i++) begin
      w[i*swd_pkg::SrcStride + swd_pkg::EnPos]     = enable[i];
      w[i*swd_pkg::SrcStride + swd_pkg::SeenLsb +: 2] = seen[i];
      w[i*swd_pkg::SrcStride + swd_pkg::ModeLsb +: 3] = mode[i];
    end
    return w;
  endfunction

  assign sigIn[swd_pkg::SrcCalendar] = clockCalendarEvent;
  assign sigIn[swd_pkg::SrcSix]      = extIrqSix;
  assign sigIn[swd_pkg::SrcSeven]    = extIrqSeven;
  assign sigIn[swd_pkg::SrcRemote]   = remoteReceiveOneEvent;

  swd_avs u_avs (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rb              (rb.slv)
  );

  ////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < swd_pkg::NumSrc; g++) begin : gSrc
    assign src[g].mode   = state_q.mode[g];
    assign src[g].enable = state_q.enable[g];
    assign src[g].clear  = rb.wrStb && rb.index == swd_pkg::IdxClear
                        && rb.wdata[swd_pkg::ClrLsb +: 5]
                           == swd_pkg::ClrCodes[g*5 +: 5];
    assign reqVec[g]     = src[g].request;
    assign seenVec[g]    = src[g].seen;

    swd_detect u_det (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .sigIn   (sigIn[g]),
      .src     (src[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prohibited codes are stored as written but detect nothing
  always_comb begin
    state_d = state_q;
    if (rb.wrStb && rb.index == swd_pkg::IdxMode) begin
      for (int i = 0; i < swd_pkg::NumSrc; i++) begin
        state_d.mode[i] =
          rb.wdata[i*swd_pkg::SrcStride + swd_pkg::ModeLsb +: 3];
        state_d.enable[i] =
          rb.wdata[i*swd_pkg::SrcStride + swd_pkg::EnPos];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < swd_pkg::NumSrc; i++) begin
        state_q.mode[i]   <= swd_pkg::ModeReset;
        state_q.enable[i] <= swd_pkg::EnReset;
      end
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (rb.index)
      swd_pkg::IdxMode:
        rb.rdata = packMode(state_q.mode, state_q.enable, seenVec);
      swd_pkg::IdxPending:
        rb.rdata = {28'h000_0000, reqVec};
      default:
        rb.rdata = 32'h0000_0000;
    endcase
  end

  assign wakeRequest = reqVec;

endmodule

// ---- bench/swd_chk.sv ----
`timescale 1ns/1ps

module swd_chk (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        extIrqSix,
  input wire logic        extIrqSeven,
  input wire logic        remoteReceiveOneEvent,
  input wire logic        clockCalendarEvent,
  input wire logic [3:0]  wakeRequest
);
  logic [31:0] modeQ;
  logic        rdDone;
  logic        wrDone;
  logic [5:0]  idx;
  assign idx = avs_address[7:2];
  assign rdDone = avs_read & ~avs_waitrequest;
  assign wrDone = avs_write & ~avs_waitrequest;
  // Shadow of mode and enable fields as written
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      modeQ <= 32'h2020_2020;
    end else if (wrDone && idx == 6'h00) begin
      modeQ <= avs_writedata & 32'h7171_7171;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////
  property p_wait_first;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no single wait");
  property p_idle_nowait;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("idle wait");
  property p_mode_rb;
    rdDone && idx == 6'h00 |-> (avs_readdata & 32'h7171_7171) == modeQ;
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback");
  property p_rsvd_zero;
    rdDone && idx == 6'h00 |-> (avs_readdata & 32'h8282_8282) == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("rsvd bit");
  property p_pend_rb;
    rdDone && idx == 6'h02 |-> avs_readdata == {28'h0, $past(wakeRequest)};
  endproperty
  a_pend_rb: assert property (p_pend_rb) else $error("pending read");
  property p_sticky;
    ($past(wakeRequest) & ~wakeRequest) != 4'h0 |->
      $past(wrDone && idx == 6'h01);
  endproperty
  a_sticky: assert property (p_sticky) else $error("wake dropped");
  property p_cal_fall;
    modeQ[0] && modeQ[6:4] == 3'h2 && $fell(clockCalendarEvent)
      |=> wakeRequest[0];
  endproperty
  a_cal_fall: assert property (p_cal_fall) else $error("calendar");
  property p_rem_rise;
    modeQ[24] && modeQ[30:28] == 3'h3 && $rose(remoteReceiveOneEvent)
      |=> wakeRequest[3];
  endproperty
  a_rem_rise: assert property (p_rem_rise) else $error("remote");
  property p_low_lvl;
    modeQ[16] && modeQ[22:20] == 3'h0 && !extIrqSeven |=> wakeRequest[2];
  endproperty
  a_low_lvl: assert property (p_low_lvl) else $error("low level");
  property p_off_quiet;
    !modeQ[8] && !wakeRequest[1] |=> !wakeRequest[1];
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled");
  c_write: cover property (wrDone && idx == 6'h00);
  c_clear: cover property (wrDone && idx == 6'h01);
  c_remote: cover property ($rose(wakeRequest[3]));
endmodule

bind swd_top swd_chk u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .extIrqSix(extIrqSix),
  .extIrqSeven(extIrqSeven), .wakeRequest(wakeRequest),
  .remoteReceiveOneEvent(remoteReceiveOneEvent),
  .clockCalendarEvent(clockCalendarEvent)
);

// ---- bench/swd_src_model.sv ----
`timescale 1ns/1ps

// Event pins: lines flip where toggle is set; calendar idles high
module swd_src_model (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] toggle,
  output logic      [3:0] lines
);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lines <= 4'h1;
    end else begin
      lines <= lines ^ toggle;
    end
  end
endmodule

// ---- bench/test_standby_wake_detect_group_c.sv ----
`timescale 1ns/1ps

module test_standby_wake_detect_group_c;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  toggle = 4'h0;
  logic [3:0]  lines;
  logic [3:0]  wakeRequest;
  int          nMismatch = 0;
  int          testsRun = 0;
  always #50 sys_clk = ~sys_clk;
  swd_top dut (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .extIrqSix(lines[1]),
    .extIrqSeven(lines[2]), .remoteReceiveOneEvent(lines[3]),
    .clockCalendarEvent(lines[0]), .wakeRequest(wakeRequest)
  );
  swd_src_model u_src (
    .sys_clk(sys_clk), .resetn(resetn), .toggle(toggle), .lines(lines)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Holds request until waitrequest is seen low, then releases
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= {idx, 2'h0};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    testsRun++;
    if (q !== exp) begin
      $display("CHECK FAILED reg %h exp %h got %h", idx, exp, q);
      nMismatch++;
    end
  endtask
  // Wake outputs looked at mid-cycle, where they are settled
  task automatic wake(input logic [3:0] exp);
    @(negedge sys_clk);
    testsRun++;
    if (wakeRequest !== exp) begin
      $display("CHECK FAILED wakeRequest exp %h got %h", exp, wakeRequest);
      nMismatch++;
    end
    @(posedge sys_clk);
  endtask
  task automatic ev(input logic [3:0] m);
    toggle <= m;
    @(posedge sys_clk);
    toggle <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk);
    nMismatch++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(6'h00, 32'h2020_2020);
    rd(6'h02, 32'h0);
    wake(4'h0);
    wr(6'h03, 32'hFFFF_FFFF);
    rd(6'h03, 32'h0);
    rd(6'h01, 32'h0);
    // Remote kept rising, calendar kept falling
    for (int c = 0; c < 5; c++) begin
      wr(6'h00, 32'h3000_0020 | (c << 20) | (c << 12));
      rd(6'h00, 32'h3000_0020 | (c << 20) | (c << 12));
    end
    wr(6'h00, 32'h3000_4020);
    wr(6'h00, 32'h3000_4120);
    ev(4'h2);
    rd(6'h00, 32'h3000_4520);
    rd(6'h02, 32'h2);
    wake(4'h2);
    ev(4'h2);
    rd(6'h00, 32'h3000_4D20);
    wr(6'h01, 32'h09);
    rd(6'h00, 32'h3000_4120);
    rd(6'h02, 32'h0);
    wr(6'h00, 32'h3101_4121);
    ev(4'h9);
    rd(6'h02, 32'hD);
    // Edges outside both-edge mode leave seen fields at zero
    rd(6'h00, 32'h3101_4121);
    wake(4'hD);
    // Low level still present, so the request sets again
    wr(6'h01, 32'h0A);
    rd(6'h02, 32'hD);
    wr(6'h01, 32'h08);
    rd(6'h02, 32'hC);
    ev(4'h1);
    rd(6'h02, 32'hC);
    // Seven to high level: disable, new mode, then enable
    wr(6'h00, 32'h3100_4121);
    wr(6'h00, 32'h3110_4121);
    wr(6'h00, 32'h3111_4121);
    wr(6'h01, 32'h0A);
    rd(6'h02, 32'h8);
    ev(4'h4);
    rd(6'h02, 32'hC);
    wake(4'hC);
    // Reset in mid-run brings back the idle values
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(6'h00, 32'h2020_2020);
    wake(4'h0);
    end_sim();
  end
endmodule
